// >>> core/bgp_gpio_top.sv
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module bgp_gpio_top
    import bgp_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port 0 header pins
    input wire logic [7:0] hdr_pin_i,
    output logic [7:0] hdr_pin_o,
    output logic [7:0] hdr_pin_oe_n,
    // Port 1 transceiver power control and line detect
    input wire logic [3:0] serial_xcvr_power_ctrl_i,
    output logic [3:0] serial_xcvr_power_ctrl_o,
    output logic [3:0] serial_xcvr_power_ctrl_oe_n,
    input wire logic [3:0] serial_line_level_detect,
    // Port 2 controls
    input wire logic [1:0] usb_port_power_ctrl_i,
    output logic [1:0] usb_port_power_ctrl_o,
    output logic [1:0] usb_port_power_ctrl_oe_n,
    input wire logic card_slave_sel_i,
    output logic card_slave_sel_o,
    output logic card_slave_sel_oe_n,
    input wire logic indicator_lamp_enable_n_i,
    output logic indicator_lamp_enable_n_o,
    output logic indicator_lamp_enable_n_oe_n,
    input wire logic memory_card_write_protect_i,
    output logic memory_card_write_protect_o,
    output logic memory_card_write_protect_oe_n,
    // Port 2 status inputs
    input wire logic [1:0] usb_overcurrent_n,
    input wire logic pci_pm_event_n,
    // Interrupt
    output logic irq
);

    // Bus decode
    logic wr_acc;
    logic hit_map;
    logic [2:0] dir_we;
    logic [2:0] out_we;
    logic irq_en_we;
    logic irq_clr_we;

    // Bank views
    bgp_byte_t dir_q [3];
    bgp_byte_t out_q [3];
    bgp_byte_t in_q [3];
    bgp_byte_t pin_i [3];
    bgp_byte_t pin_o [3];
    bgp_byte_t pin_oe_n [3];

    logic [6:0] ev_stat;
    logic [6:0] ev_en;
    logic [6:0] ev_lvl;

    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pready_ff;
    logic pslverr_ff;
    logic nxt_slverr;

    // Exact byte-address match inside the map
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // A write lands only in the access cycle that completes
    assign wr_acc = psel && penable && pwrite && pready_ff;

    assign dir_we[0] = wr_acc && addr_is(paddr, BGP_P0_DIR_OFF);
    assign dir_we[1] = wr_acc && addr_is(paddr, BGP_P1_DIR_OFF);
    assign dir_we[2] = wr_acc && addr_is(paddr, BGP_P2_DIR_OFF);
    assign out_we[0] = wr_acc && addr_is(paddr, BGP_P0_OUT_OFF);
    assign out_we[1] = wr_acc && addr_is(paddr, BGP_P1_OUT_OFF);
    assign out_we[2] = wr_acc && addr_is(paddr, BGP_P2_OUT_OFF);
    assign irq_en_we = wr_acc && addr_is(paddr, BGP_IRQ_EN_OFF);
    assign irq_clr_we = wr_acc && addr_is(paddr, BGP_IRQ_CLR_OFF);

    // Gather pins into uniform banks; status lines have no driver side
    assign pin_i[0] = hdr_pin_i;
    assign pin_i[1] = {serial_line_level_detect, serial_xcvr_power_ctrl_i};
    assign pin_i[2] = {memory_card_write_protect_i, pci_pm_event_n, usb_overcurrent_n,
                       indicator_lamp_enable_n_i, card_slave_sel_i, usb_port_power_ctrl_i};

    // Port 0: all eight pins programmable
    bgp_pin_bank #(
        .DRV_MASK(8'hFF)
    ) u_bank0 (
        .pclk(pclk),
        .presetn(presetn),
        .dir_we(dir_we[0]),
        .out_we(out_we[0]),
        .wdata(pwdata[7:0]),
        .dir_q(dir_q[0]),
        .out_q(out_q[0]),
        .in_q(in_q[0]),
        .pin_i(pin_i[0]),
        .pin_o(pin_o[0]),
        .pin_oe_n(pin_oe_n[0])
    );

    // Port 1: detect bits are never driven, whatever software writes
    bgp_pin_bank #(
        .DRV_MASK(BGP_P1_DRV_MASK)
    ) u_bank1 (
        .pclk(pclk),
        .presetn(presetn),
        .dir_we(dir_we[1]),
        .out_we(out_we[1]),
        .wdata(pwdata[7:0]),
        .dir_q(dir_q[1]),
        .out_q(out_q[1]),
        .in_q(in_q[1]),
        .pin_i(pin_i[1]),
        .pin_o(pin_o[1]),
        .pin_oe_n(pin_oe_n[1])
    );

    // Port 2: overcurrent and power event bits forced to input
    bgp_pin_bank #(
        .DRV_MASK(BGP_P2_DRV_MASK)
    ) u_bank2 (
        .pclk(pclk),
        .presetn(presetn),
        .dir_we(dir_we[2]),
        .out_we(out_we[2]),
        .wdata(pwdata[7:0]),
        .dir_q(dir_q[2]),
        .out_q(out_q[2]),
        .in_q(in_q[2]),
        .pin_i(pin_i[2]),
        .pin_o(pin_o[2]),
        .pin_oe_n(pin_oe_n[2])
    );

    // Header pins
    assign hdr_pin_o = pin_o[0];
    assign hdr_pin_oe_n = pin_oe_n[0];

    // Transceiver power: 0 power save, 1 forced on; released when input
    assign serial_xcvr_power_ctrl_o = pin_o[1][BGP_P1_PWR_LSB +: 4];
    assign serial_xcvr_power_ctrl_oe_n = pin_oe_n[1][BGP_P1_PWR_LSB +: 4];

    // USB power switch: 0 off, 1 on
    assign usb_port_power_ctrl_o = pin_o[2][BGP_P2_USB_LSB +: 2];
    assign usb_port_power_ctrl_oe_n = pin_oe_n[2][BGP_P2_USB_LSB +: 2];

    // Card slot role: 0 master, 1 slave
    assign card_slave_sel_o = pin_o[2][BGP_P2_ROLE];
    assign card_slave_sel_oe_n = pin_oe_n[2][BGP_P2_ROLE];

    // Lamps lit when driven low
    assign indicator_lamp_enable_n_o = pin_o[2][BGP_P2_LAMP];
    assign indicator_lamp_enable_n_oe_n = pin_oe_n[2][BGP_P2_LAMP];

    // Write protect: 0 writable, 1 protected
    assign memory_card_write_protect_o = pin_o[2][BGP_P2_WP];
    assign memory_card_write_protect_oe_n = pin_oe_n[2][BGP_P2_WP];

    // Events: detect rise, overcurrent fall, power event fall
    assign ev_lvl = {in_q[2][BGP_P2_PME], in_q[2][BGP_P2_OVC_LSB +: 2],
                     in_q[1][BGP_P1_DET_LSB +: 4]};

    bgp_event_irq u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .ev_lvl(ev_lvl),
        .ev_pol(7'h0F),
        .en_we(irq_en_we),
        .clr_we(irq_clr_we),
        .wdata(pwdata[6:0]),
        .stat_q(ev_stat),
        .en_q(ev_en),
        .irq(irq)
    );

    // Read mux and unmapped detection
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        hit_map = 1'b1;
        unique case (paddr)
            BGP_P0_DIR_OFF: nxt_prdata[7:0] = dir_q[0];
            BGP_P0_OUT_OFF: nxt_prdata[7:0] = out_q[0];
            BGP_P0_IN_OFF: nxt_prdata[7:0] = in_q[0];
            BGP_P1_DIR_OFF: nxt_prdata[7:0] = dir_q[1];
            BGP_P1_OUT_OFF: nxt_prdata[7:0] = out_q[1];
            BGP_P1_IN_OFF: nxt_prdata[7:0] = in_q[1];
            BGP_P2_DIR_OFF: nxt_prdata[7:0] = dir_q[2];
            BGP_P2_OUT_OFF: nxt_prdata[7:0] = out_q[2];
            BGP_P2_IN_OFF: nxt_prdata[7:0] = in_q[2];
            BGP_IRQ_STAT_OFF: nxt_prdata[6:0] = ev_stat;
            BGP_IRQ_EN_OFF: nxt_prdata[6:0] = ev_en;
            BGP_IRQ_CLR_OFF: nxt_prdata = 32'h0000_0000;
            default: hit_map = 1'b0;
        endcase
        nxt_slverr = !hit_map || (pwrite && addr_is(paddr, BGP_IRQ_STAT_OFF));
    end

    // One wait state: ready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= psel && penable && !pready_ff;
        end
    end

    // Answer registers loaded with the ready strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (psel && penable && !pready_ff) begin
            prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
            pslverr_ff <= nxt_slverr;
        end else begin
            pslverr_ff <= 1'b0;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

endmodule
`default_nettype wire

// >>> core/bgp_pkg.sv
package bgp_pkg;

    // Register byte offsets
    localparam logic [7:0] BGP_P0_DIR_OFF = 8'h00;
    localparam logic [7:0] BGP_P0_OUT_OFF = 8'h04;
    localparam logic [7:0] BGP_P0_IN_OFF = 8'h08;
    localparam logic [7:0] BGP_P1_DIR_OFF = 8'h0C;
    localparam logic [7:0] BGP_P1_OUT_OFF = 8'h10;
    localparam logic [7:0] BGP_P1_IN_OFF = 8'h14;
    localparam logic [7:0] BGP_P2_DIR_OFF = 8'h18;
    localparam logic [7:0] BGP_P2_OUT_OFF = 8'h1C;
    localparam logic [7:0] BGP_P2_IN_OFF = 8'h20;
    localparam logic [7:0] BGP_IRQ_STAT_OFF = 8'h24;
    localparam logic [7:0] BGP_IRQ_EN_OFF = 8'h28;
    localparam logic [7:0] BGP_IRQ_CLR_OFF = 8'h2C;

    // Port 1 layout: bits 3:0 transceiver power, bits 7:4 line detect
    localparam int BGP_P1_PWR_LSB = 0;
    localparam int BGP_P1_DET_LSB = 4;
    // Port 2 layout
    localparam int BGP_P2_USB_LSB = 0;
    localparam int BGP_P2_ROLE = 2;
    localparam int BGP_P2_LAMP = 3;
    localparam int BGP_P2_OVC_LSB = 4;
    localparam int BGP_P2_PME = 6;
    localparam int BGP_P2_WP = 7;

    // Reset values: all pins input, output latches zero
    localparam logic [7:0] BGP_DIR_RST = 8'h00;
    localparam logic [7:0] BGP_OUT_RST = 8'h00;
    localparam logic [7:0] BGP_IRQ_RST = 8'h00;

    // Port 1/2 bits that may actually be driven
    localparam logic [7:0] BGP_P1_DRV_MASK = 8'h0F;
    localparam logic [7:0] BGP_P2_DRV_MASK = 8'h8F;

    // Interrupt status layout
    localparam int BGP_EV_DET_LSB = 0;
    localparam int BGP_EV_OVC_LSB = 4;
    localparam int BGP_EV_PME = 6;
    localparam int BGP_EV_W = 7;

    typedef logic [7:0] bgp_byte_t;

endpackage

// >>> core/bgp_pin_bank.sv
`timescale 1ns/1ps
`default_nettype none
// One 8-pin bank: direction, output latch, tristate drive, sampled input
module bgp_pin_bank
    import bgp_pkg::*;
#(
    parameter logic [7:0] DRV_MASK = 8'hFF
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Software side
    input wire logic dir_we,
    input wire logic out_we,
    input wire logic [7:0] wdata,
    output logic [7:0] dir_q,
    output logic [7:0] out_q,
    output logic [7:0] in_q,
    // Pin side
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_n
);

    logic [7:0] dir_ff;
    logic [7:0] out_ff;
    logic [7:0] smp_ff;
    logic [7:0] drv_ff;
    logic [7:0] oen_ff;

    // Direction latch; non-drivable bits stay input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_ff <= BGP_DIR_RST;
        end else if (dir_we) begin
            dir_ff <= wdata & DRV_MASK;
        end
    end

    // Output value latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ff <= BGP_OUT_RST;
        end else if (out_we) begin
            out_ff <= wdata;
        end
    end

    // Pin drivers registered so ports come straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv_ff <= BGP_OUT_RST;
            oen_ff <= ~BGP_DIR_RST;
        end else begin
            drv_ff <= out_ff;
            oen_ff <= ~dir_ff;
        end
    end

    // Input sample; output pins read back their pad level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            smp_ff <= 8'h00;
        end else begin
            smp_ff <= pin_i;
        end
    end

    assign dir_q = dir_ff;
    assign out_q = out_ff;
    assign in_q = smp_ff;
    assign pin_o = drv_ff;
    assign pin_oe_n = oen_ff;

endmodule
`default_nettype wire

// >>> core/bgp_event_irq.sv
`timescale 1ns/1ps
`default_nettype none
// Sticky falling/rising event capture with enable and write-one clear
module bgp_event_irq
    import bgp_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Event levels, already sampled
    input wire logic [6:0] ev_lvl,
    input wire logic [6:0] ev_pol,
    // Software side
    input wire logic en_we,
    input wire logic clr_we,
    input wire logic [6:0] wdata,
    output logic [6:0] stat_q,
    output logic [6:0] en_q,
    output logic irq
);

    logic [6:0] prev_ff;
    logic [6:0] stat_ff;
    logic [6:0] en_ff;
    logic irq_ff;
    logic [6:0] hit;

    // Event when a level enters its active state
    assign hit = (ev_lvl ~^ ev_pol) & ~(prev_ff ~^ ev_pol);

    // Previous level resets like the input samplers feeding ev_lvl (all zero),
    // so the first real sample after reset is never taken for a falling edge; a detect line high out of reset counts as a rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_ff <= BGP_IRQ_RST[6:0];
        end else begin
            prev_ff <= ev_lvl;
        end
    end

    // Sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_ff <= BGP_IRQ_RST[6:0];
        end else begin
            stat_ff <= (stat_ff & ~(clr_we ? wdata : 7'h00)) | hit;
        end
    end

    // Enable mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff <= BGP_IRQ_RST[6:0];
        end else if (en_we) begin
            en_ff <= wdata;
        end
    end

    // Registered level interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(stat_ff & en_ff);
        end
    end

    assign stat_q = stat_ff;
    assign en_q = en_ff;
    assign irq = irq_ff;

endmodule
`default_nettype wire

// >>> tb/bgp_sva.sv
`timescale 1ns/1ps
`default_nettype none
module bgp_sva
    import bgp_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic [7:0] hdr_pin_o,
    input wire logic [7:0] hdr_pin_oe_n,
    input wire logic [3:0] serial_xcvr_power_ctrl_oe_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Completed writes; pins trail them by a few edges
    logic done, wr_p0, wr_d0, wr_d1;
    assign done = psel && penable && pready && pwrite;
    assign wr_d0 = done && paddr == BGP_P0_DIR_OFF;
    assign wr_p0 = wr_d0 || (done && paddr == BGP_P0_OUT_OFF);
    assign wr_d1 = done && paddr == BGP_P1_DIR_OFF;

    chk_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("pready not in second access cycle");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_pair: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_unmapped_err: assert property (pready && paddr > BGP_IRQ_CLR_OFF |-> pslverr)
        else $error("unmapped access not refused");
    chk_stat_ro: assert property (pready && pwrite && paddr == BGP_IRQ_STAT_OFF |-> pslverr)
        else $error("status write not refused");
    chk_rd_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_rst_inputs: assert property ($rose(presetn) |-> &hdr_pin_oe_n && &serial_xcvr_power_ctrl_oe_n)
        else $error("pin driven right after reset");
    chk_hdr_hold: assert property ($changed(hdr_pin_o) |-> $past(wr_p0) || $past(wr_p0, 2) || $past(wr_p0, 3))
        else $error("header output moved without a write");
    chk_hdr_dir: assert property ($changed(hdr_pin_oe_n) |-> $past(wr_d0) || $past(wr_d0, 2) || $past(wr_d0, 3))
        else $error("header direction moved without a write");
    chk_xcvr_dir: assert property ($changed(serial_xcvr_power_ctrl_oe_n) |-> $past(wr_d1) || $past(wr_d1, 2))
        else $error("transceiver direction moved without a write");
endmodule

bind bgp_gpio_top bgp_sva u_sva (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .hdr_pin_o(hdr_pin_o),
    .hdr_pin_oe_n(hdr_pin_oe_n),
    .serial_xcvr_power_ctrl_oe_n(serial_xcvr_power_ctrl_oe_n)
);
`default_nettype wire

// >>> tb/bgp_board.sv
`timescale 1ns/1ps
`default_nettype none
// Board wiring, lines packed as {wp, lamp, role, usb[1:0], xcvr[3:0], header[7:0]}
module bgp_board #(
    // Strap levels of the control lines; header lines follow the outside driver
    parameter logic [8:0] STRAP = 9'h03F
) (
    // Outside driver of the header
    input wire logic [7:0] hdr_ext,
    // Block side
    input wire logic [16:0] drv_o,
    input wire logic [16:0] drv_oe_n,
    // Resolved levels
    output logic [16:0] pin_w
);
    // A released line falls to its strap or, on the header, to the outside driver, so a stale drive value never lingers
    assign pin_w = (drv_oe_n & {STRAP, hdr_ext}) | (~drv_oe_n & drv_o);
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bgp_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq;
    logic [7:0] hdr_ext = 8'h00;
    wire logic [16:0] drv_o;
    wire logic [16:0] drv_oe_n;
    logic [16:0] pin_w;
    logic [3:0] detect = 4'h0;
    logic [1:0] ovc_n = 2'h3;
    logic pm_n = 1'b1;
    logic [7:0] rst_regs [9] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h24, 8'h28, 8'h2C};
    logic [7:0] p2v [2] = '{8'h86, 8'h09};
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;

    always #12.5 pclk = ~pclk;

    bgp_gpio_top u_dut (
        .pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hdr_pin_i(pin_w[7:0]), .hdr_pin_o(drv_o[7:0]), .hdr_pin_oe_n(drv_oe_n[7:0]),
        .serial_xcvr_power_ctrl_i(pin_w[11:8]), .serial_xcvr_power_ctrl_o(drv_o[11:8]),
        .serial_xcvr_power_ctrl_oe_n(drv_oe_n[11:8]), .serial_line_level_detect(detect),
        .usb_port_power_ctrl_i(pin_w[13:12]), .usb_port_power_ctrl_o(drv_o[13:12]),
        .usb_port_power_ctrl_oe_n(drv_oe_n[13:12]),
        .card_slave_sel_i(pin_w[14]), .card_slave_sel_o(drv_o[14]),
        .card_slave_sel_oe_n(drv_oe_n[14]),
        .indicator_lamp_enable_n_i(pin_w[15]), .indicator_lamp_enable_n_o(drv_o[15]),
        .indicator_lamp_enable_n_oe_n(drv_oe_n[15]),
        .memory_card_write_protect_i(pin_w[16]), .memory_card_write_protect_o(drv_o[16]),
        .memory_card_write_protect_oe_n(drv_oe_n[16]),
        .usb_overcurrent_n(ovc_n), .pci_pm_event_n(pm_n), .irq(irq)
    );

    bgp_board u_board (.hdr_ext(hdr_ext), .drv_o(drv_o), .drv_oe_n(drv_oe_n), .pin_w(pin_w));

    task automatic results();
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; request held until the edge that samples pready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic x);
        logic [31:0] q;
        logic e;
        xfer(1'b1, a, d, q, e);
        chk({31'h0, e}, {31'h0, x});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        xfer(1'b0, a, 32'h0, q, e);
        chk(q, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask

    // Drive flops and event capture trail a write or pin change by a few edges
    task automatic settle();
        repeat (4) @(posedge pclk);
    endtask

    // Hang guard: the sequence needs a few hundred cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            results();
        end
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rst_regs[i]) rd_chk(rst_regs[i], 32'h0, 1'b0);
        chk({15'h0, drv_oe_n}, 32'h1FFFF);
        chk({23'h0, pin_w[16:8]}, 32'h03F);
        // Header: mixed directions, then swapped, then all out
        wr(BGP_P0_OUT_OFF, 32'hA5, 1'b0);
        wr(BGP_P0_DIR_OFF, 32'h0F, 1'b0);
        hdr_ext <= 8'h3C;
        settle();
        chk({24'h0, drv_oe_n[7:0]}, 32'hF0);
        rd_chk(BGP_P0_IN_OFF, 32'h35, 1'b0);
        wr(BGP_P0_DIR_OFF, 32'hF0, 1'b0);
        settle();
        chk({24'h0, pin_w[7:0]}, 32'hAC);
        wr(BGP_P0_OUT_OFF, 32'h5A, 1'b0);
        wr(BGP_P0_DIR_OFF, 32'hFF, 1'b0);
        settle();
        chk({24'h0, pin_w[7:0]}, 32'h5A);
        // Transceiver power and line detect; status bits refuse output
        wr(BGP_P1_DIR_OFF, 32'hFF, 1'b0);
        rd_chk(BGP_P1_DIR_OFF, 32'h0F, 1'b0);
        wr(BGP_P1_OUT_OFF, 32'h05, 1'b0);
        detect <= 4'hA;
        settle();
        chk({28'h0, pin_w[11:8]}, 32'h5);
        rd_chk(BGP_P1_IN_OFF, 32'hA5, 1'b0);
        wr(BGP_P1_DIR_OFF, 32'h00, 1'b0);
        settle();
        chk({28'h0, pin_w[11:8]}, 32'hF);
        // Port 2 controls in both levels
        wr(BGP_P2_DIR_OFF, 32'hFF, 1'b0);
        rd_chk(BGP_P2_DIR_OFF, 32'h8F, 1'b0);
        foreach (p2v[i]) begin
            wr(BGP_P2_OUT_OFF, {24'h0, p2v[i]}, 1'b0);
            settle();
            chk({30'h0, pin_w[13:12]}, {30'h0, p2v[i][1:0]});
            chk({31'h0, pin_w[14]}, {31'h0, p2v[i][2]});
            chk({31'h0, pin_w[15]}, {31'h0, p2v[i][3]});
            chk({31'h0, pin_w[16]}, {31'h0, p2v[i][7]});
        end
        ovc_n <= 2'h1;
        pm_n <= 1'b0;
        settle();
        rd_chk(BGP_P2_IN_OFF, 32'h19, 1'b0);
        wr(BGP_P2_DIR_OFF, 32'h00, 1'b0);
        settle();
        chk({27'h0, pin_w[16:12]}, 32'h03);
        // Events: sticky, masked, cleared, refused writes
        rd_chk(BGP_IRQ_STAT_OFF, 32'h6A, 1'b0);
        chk({31'h0, irq}, 32'h0);
        wr(BGP_IRQ_EN_OFF, 32'h40, 1'b0);
        rd_chk(BGP_IRQ_EN_OFF, 32'h40, 1'b0);
        settle();
        chk({31'h0, irq}, 32'h1);
        wr(BGP_IRQ_CLR_OFF, 32'h40, 1'b0);
        settle();
        chk({31'h0, irq}, 32'h0);
        ovc_n <= 2'h0;
        pm_n <= 1'b1;
        settle();
        pm_n <= 1'b0;
        settle();
        rd_chk(BGP_IRQ_STAT_OFF, 32'h7A, 1'b0);
        chk({31'h0, irq}, 32'h1);
        wr(BGP_IRQ_EN_OFF, 32'h00, 1'b0);
        settle();
        chk({31'h0, irq}, 32'h0);
        wr(BGP_IRQ_STAT_OFF, 32'h7F, 1'b1);
        wr(BGP_IRQ_CLR_OFF, 32'h7F, 1'b0);
        rd_chk(BGP_IRQ_STAT_OFF, 32'h0, 1'b0);
        // A power event captured on the edge its clear lands must stay set
        pm_n <= 1'b1;
        settle();
        fork
            wr(BGP_IRQ_CLR_OFF, 32'h40, 1'b0);
            begin
                repeat (2) @(posedge pclk);
                pm_n <= 1'b0;
            end
        join
        rd_chk(BGP_IRQ_STAT_OFF, 32'h40, 1'b0);
        rd_chk(8'h30, 32'h0, 1'b1);
        rd_chk(8'h05, 32'h0, 1'b1);
        results();
    end
endmodule
`default_nettype wire
